/* File: rtl/cpu_arith_status_core.sv */
// cpu arithmetic, bit processor, status word, stack and program pointer
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module cpu_arith_status_core
  import cpu_core_pkg::*;
#(
  parameter int DPTR_COUNT = 8,
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic event_branch,
  input wire logic [15:0] event_target,
  output logic [15:0] iptr_out,
  output logic [4:0] bank_base_out
);
  initial begin
    if (DPTR_COUNT != 8 || ADDR_W < 8)
      $error("unsupported parameters");
  end

  // ================================================================
  // state
  logic [7:0] acc_r, breg_r, status_r, stack_r, opnd_r, result_r;
  logic [15:0] iptr_r, target_r;
  logic [15:0] dptr_r [DPTR_COUNT];
  logic [2:0] dpsel_r;
  logic [11:0] cmd_r;
  logic [7:0] bits_r;
  exec_state_e state_r;
  logic aw_got_r, w_got_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;

  function automatic logic parity8(input logic [7:0] v);
    return ^v;
  endfunction : parity8

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
      if (be[i]) m[i*8 +: 8] = nw[i*8 +: 8];
    return m;
  endfunction : merge

  // ================================================================
  // AXI write side
  logic wr_hit;
  logic [7:0] wa;
  logic wr_fire;
  assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (clk_en) begin
      s_axi_awready <= !aw_got_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_got_r && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign wa = awaddr_r[7:0];
  assign wr_hit = wa == OFF_STATUS || wa == OFF_STACK || wa == OFF_ACC ||
    wa == OFF_BREG || wa == OFF_IPTR || wa == OFF_DPSEL ||
    wa == OFF_DPTR || wa == OFF_OPND || wa == OFF_CMD ||
    wa == OFF_RESULT || wa == OFF_BANK;
  logic [31:0] wm;
  assign wm = merge(32'h0, wdata_r, wstrb_r);
  logic [31:0] ip_m, dp_m;
  assign ip_m = merge({16'h0, iptr_r}, wdata_r, wstrb_r);
  assign dp_m = merge({16'h0, dptr_r[dpsel_r]}, wdata_r, wstrb_r);

  // ================================================================
  // AXI read side
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr[7:0])
      OFF_STATUS: rd_mux = {24'h0, status_r};
      OFF_STACK: rd_mux = {24'h0, stack_r};
      OFF_ACC: rd_mux = {24'h0, acc_r};
      OFF_BREG: rd_mux = {24'h0, breg_r};
      OFF_IPTR: rd_mux = {16'h0, iptr_r};
      OFF_DPSEL: rd_mux = {29'h0, dpsel_r};
      OFF_DPTR: rd_mux = {16'h0, dptr_r[dpsel_r]};
      OFF_OPND: rd_mux = {24'h0, opnd_r};
      OFF_CMD: rd_mux = {19'h0, state_r == ST_IDLE ? 1'b0 : 1'b1, cmd_r};
      OFF_RESULT: rd_mux = {24'h0, result_r};
      OFF_BANK: rd_mux = {24'h0, bits_r};
      default: begin
        rd_mux = UNMAPPED_VALUE;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ================================================================
  // decode and ALU
  alu_op_e op;
  logic [2:0] bidx;
  logic bsel, bval, cy;
  logic [8:0] sum;
  logic [4:0] hsum;
  logic [15:0] prod;
  logic [7:0] a_nxt, b_nxt, bits_nxt, res_nxt;
  logic [7:0] sts_nxt;
  logic [7:0] sp_nxt;
  logic [15:0] ip_nxt;
  logic [7:0] da_tmp;
  logic da_c;
  always_comb begin
    op = alu_op_e'(cmd_r[CMD_OP_LSB +: 6]);
    bidx = cmd_r[CMD_BIT_LSB +: 3];
    bval = bits_r[bidx];
    bsel = bval ^ cmd_r[CMD_INV_POS];
    cy = status_r[STS_CARRY];
    a_nxt = acc_r;
    b_nxt = breg_r;
    bits_nxt = bits_r;
    res_nxt = result_r;
    sts_nxt = status_r;
    sp_nxt = stack_r;
    ip_nxt = iptr_r + 16'h0001;
    sum = 9'h0;
    hsum = 5'h0;
    prod = acc_r * breg_r;
    da_tmp = acc_r;
    da_c = cy;
    case (op)
      OP_ADD, OP_ADDC: begin
        sum = {1'b0, acc_r} + {1'b0, opnd_r} + {8'h0, op == OP_ADDC && cy};
        hsum = {1'b0, acc_r[3:0]} + {1'b0, opnd_r[3:0]} +
          {4'h0, op == OP_ADDC && cy};
        a_nxt = sum[7:0];
        sts_nxt[STS_CARRY] = sum[8];
        sts_nxt[STS_HALF] = hsum[4];
        sts_nxt[STS_EXCESS] = (acc_r[7] == opnd_r[7]) && (sum[7] != acc_r[7]);
      end
      OP_SUBB: begin
        sum = {1'b0, acc_r} - {1'b0, opnd_r} - {8'h0, cy};
        hsum = {1'b0, acc_r[3:0]} - {1'b0, opnd_r[3:0]} - {4'h0, cy};
        a_nxt = sum[7:0];
        sts_nxt[STS_CARRY] = sum[8];
        sts_nxt[STS_HALF] = hsum[4];
        sts_nxt[STS_EXCESS] = (acc_r[7] != opnd_r[7]) && (sum[7] != acc_r[7]);
      end
      OP_INC: a_nxt = acc_r + 8'h01;
      OP_DEC: a_nxt = acc_r - 8'h01;
      OP_MUL: begin
        a_nxt = prod[7:0];
        b_nxt = prod[15:8];
        sts_nxt[STS_CARRY] = 1'b0;
        sts_nxt[STS_EXCESS] = prod[15:8] != 8'h00;
      end
      OP_DIV: begin
        sts_nxt[STS_CARRY] = 1'b0;
        sts_nxt[STS_EXCESS] = breg_r == 8'h00;
        if (breg_r != 8'h00) begin
          a_nxt = acc_r / breg_r;
          b_nxt = acc_r % breg_r;
        end
      end
      OP_DA: begin
        if (acc_r[3:0] > 4'h9 || status_r[STS_HALF]) begin
          sum = {1'b0, da_tmp} + 9'h006;
          da_tmp = sum[7:0];
          da_c = da_c | sum[8];
        end
        if (da_tmp[7:4] > 4'h9 || da_c) begin
          sum = {1'b0, da_tmp} + 9'h060;
          da_tmp = sum[7:0];
          da_c = da_c | sum[8];
        end
        a_nxt = da_tmp;
        sts_nxt[STS_CARRY] = da_c;
      end
      OP_CMP: begin
        sts_nxt[STS_CARRY] = acc_r < opnd_r;
        if (acc_r != opnd_r) ip_nxt = target_r;
      end
      OP_AND: a_nxt = acc_r & opnd_r;
      OP_OR: a_nxt = acc_r | opnd_r;
      OP_XOR: a_nxt = acc_r ^ opnd_r;
      OP_CPL: a_nxt = ~acc_r;
      OP_RR: a_nxt = {acc_r[0], acc_r[7:1]};
      OP_RL: a_nxt = {acc_r[6:0], acc_r[7]};
      OP_SWAP: a_nxt = {acc_r[3:0], acc_r[7:4]};
      OP_BSET: bits_nxt[bidx] = 1'b1;
      OP_BCLR: bits_nxt[bidx] = 1'b0;
      OP_BCPL: bits_nxt[bidx] = ~bval;
      OP_JB: if (bval) ip_nxt = target_r;
      OP_JNB: if (!bval) ip_nxt = target_r;
      OP_JBC: if (bval) begin
        ip_nxt = target_r;
        bits_nxt[bidx] = 1'b0;
      end
      OP_MOVCB: sts_nxt[STS_CARRY] = bval;
      OP_MOVBC: bits_nxt[bidx] = cy;
      OP_ANLC: sts_nxt[STS_CARRY] = cy & bsel;
      OP_ORLC: sts_nxt[STS_CARRY] = cy | bsel;
      OP_CLRC: sts_nxt[STS_CARRY] = 1'b0;
      OP_SETC: sts_nxt[STS_CARRY] = 1'b1;
      OP_CPLC: sts_nxt[STS_CARRY] = ~cy;
      OP_PUSH, OP_CALL: begin
        sp_nxt = stack_r + 8'h01;
        res_nxt = sp_nxt;
        if (op == OP_CALL) ip_nxt = target_r;
      end
      OP_POP, OP_RET: begin
        res_nxt = stack_r;
        sp_nxt = stack_r - 8'h01;
        if (op == OP_RET) ip_nxt = target_r;
      end
      OP_JMP: ip_nxt = target_r;
      default: ;
    endcase
    if (event_branch) ip_nxt = event_target;
    sts_nxt[STS_PARITY] = parity8(a_nxt);
  end

  // ================================================================
  // executing commands and software register writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      acc_r <= 8'h00;
      breg_r <= 8'h00;
      status_r <= STATUS_RESET;
      stack_r <= STACK_RESET;
      iptr_r <= IPTR_RESET;
      target_r <= 16'h0000;
      opnd_r <= 8'h00;
      result_r <= 8'h00;
      cmd_r <= 12'h000;
      bits_r <= 8'h00;
      dpsel_r <= 3'h0;
      for (int i = 0; i < DPTR_COUNT; i++) dptr_r[i] <= 16'h0000;
    end else if (clk_en) begin
      case (state_r)
        ST_IDLE: if (wr_fire && wa == OFF_CMD && wstrb_r[0]) begin
          cmd_r <= wdata_r[11:0];
          target_r <= wdata_r[31:16];
          state_r <= ST_EXEC;
        end
        ST_EXEC: begin
          acc_r <= a_nxt;
          breg_r <= b_nxt;
          status_r <= sts_nxt;
          stack_r <= sp_nxt;
          iptr_r <= ip_nxt;
          bits_r <= bits_nxt;
          result_r <= res_nxt;
          state_r <= ST_DONE;
        end
        ST_DONE: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
      if (wr_fire && state_r != ST_EXEC) begin
        case (wa)
          OFF_STATUS: if (wstrb_r[0])
            status_r <= {wm[7:1], parity8(acc_r)};
          OFF_STACK: if (wstrb_r[0]) stack_r <= wm[7:0];
          OFF_ACC: if (wstrb_r[0]) begin
            acc_r <= wm[7:0];
            status_r[STS_PARITY] <= parity8(wm[7:0]);
          end
          OFF_BREG: if (wstrb_r[0]) breg_r <= wm[7:0];
          OFF_IPTR: iptr_r <= ip_m[15:0];
          OFF_DPSEL: if (wstrb_r[0]) dpsel_r <= wm[2:0];
          OFF_DPTR: dptr_r[dpsel_r] <= dp_m[15:0];
          OFF_OPND: if (wstrb_r[0]) opnd_r <= wm[7:0];
          OFF_BANK: if (wstrb_r[0]) bits_r <= wm[7:0];
          default: ;
        endcase
      end
    end
  end

  // ================================================================
  // outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      iptr_out <= IPTR_RESET;
      bank_base_out <= 5'h00;
    end else if (clk_en) begin
      iptr_out <= iptr_r;
      bank_base_out <= {status_r[STS_BANKH], status_r[STS_BANKL],
        3'b000};
    end
  end
endmodule : cpu_arith_status_core
`default_nettype wire

/* File: rtl/cpu_core_pkg.sv */
// package: register offsets, fields, reset values and ALU/bit op codes
package cpu_core_pkg;
  // ================================================================
  // register map (byte addresses on the AXI4-Lite slave)
  localparam logic [7:0] OFF_STATUS = 8'hd0;
  localparam logic [7:0] OFF_STACK = 8'hd4;
  localparam logic [7:0] OFF_ACC = 8'he0;
  localparam logic [7:0] OFF_BREG = 8'hf0;
  localparam logic [7:0] OFF_IPTR = 8'hc0;
  localparam logic [7:0] OFF_DPSEL = 8'hc4;
  localparam logic [7:0] OFF_DPTR = 8'hc8;
  localparam logic [7:0] OFF_OPND = 8'hb0;
  localparam logic [7:0] OFF_CMD = 8'hb4;
  localparam logic [7:0] OFF_RESULT = 8'hb8;
  localparam logic [7:0] OFF_BANK = 8'hbc;
  // ================================================================
  // status word fields and reset values
  localparam int STS_CARRY = 7;
  localparam int STS_HALF = 6;
  localparam int STS_USER0 = 5;
  localparam int STS_BANKH = 4;
  localparam int STS_BANKL = 3;
  localparam int STS_EXCESS = 2;
  localparam int STS_USER1 = 1;
  localparam int STS_PARITY = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] STACK_RESET = 8'h07;
  localparam logic [15:0] IPTR_RESET = 16'h0000;
  localparam logic [31:0] UNMAPPED_VALUE = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ================================================================
  // command word: op in [5:0], bit index in [10:8], bit invert in [11]
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BIT_LSB = 8;
  localparam int CMD_INV_POS = 11;
  typedef enum logic [5:0] {
    OP_ADD = 6'h00, OP_ADDC = 6'h01, OP_SUBB = 6'h02, OP_INC = 6'h03,
    OP_DEC = 6'h04, OP_MUL = 6'h05, OP_DIV = 6'h06, OP_DA = 6'h07,
    OP_CMP = 6'h08, OP_AND = 6'h09, OP_OR = 6'h0a, OP_XOR = 6'h0b,
    OP_CPL = 6'h0c, OP_RR = 6'h0d, OP_RL = 6'h0e, OP_SWAP = 6'h0f,
    OP_BSET = 6'h10, OP_BCLR = 6'h11, OP_BCPL = 6'h12, OP_JB = 6'h13,
    OP_JNB = 6'h14, OP_JBC = 6'h15, OP_MOVCB = 6'h16, OP_MOVBC = 6'h17,
    OP_ANLC = 6'h18, OP_ORLC = 6'h19, OP_PUSH = 6'h1a, OP_POP = 6'h1b,
    OP_CALL = 6'h1c, OP_RET = 6'h1d, OP_JMP = 6'h1e, OP_NOP = 6'h1f,
    OP_CLRC = 6'h20, OP_SETC = 6'h21, OP_CPLC = 6'h22
  } alu_op_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_EXEC = 3'b010, ST_DONE = 3'b100
  } exec_state_e;
endpackage : cpu_core_pkg

/* File: sim/cpu_arith_status_core_chk.sv */
// bus, reset and output checks for the cpu arithmetic and status core
`timescale 1ns/1ps
`default_nettype none
module cpu_arith_status_core_chk
  import cpu_core_pkg::*;
#(
  parameter int DPTR_COUNT = 8,
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] iptr_out,
  input wire logic [4:0] bank_base_out
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ==============================================================
  // register bus answers
  b_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write response dropped");
  r_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read data dropped");
  r_cause_a:
    assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid
      && s_axi_arready)) else $error("read answer without request");
  wr_excl_a:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
  rd_excl_a:
    assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
  b_once_a:
    assert property (s_axi_bvalid && s_axi_bready && clk_en |=>
      !s_axi_bvalid) else $error("write response repeated");
  unmapped_rd_a:
    assert property (s_axi_arvalid && s_axi_arready && clk_en
      && s_axi_araddr == '0 |=> s_axi_rvalid
      && s_axi_rresp == RESP_SLVERR && s_axi_rdata == UNMAPPED_VALUE)
      else $error("unmapped read not refused");
  // ==============================================================
  // reset, freeze and bank base
  reset_out_a:
    assert property ($rose(aresetn) |-> !s_axi_awready && !s_axi_arready
      && !s_axi_bvalid && !s_axi_rvalid && iptr_out == 16'h0000
      && bank_base_out == 5'h00) else $error("outputs wrong after reset");
  freeze_a:
    assert property (!clk_en |=> $stable(iptr_out)
      && $stable(bank_base_out) && $stable(s_axi_bvalid))
      else $error("state moved while clock enable low");
  bank_align_a:
    assert property (bank_base_out[2:0] == 3'b000)
      else $error("bank base not a multiple of eight");
endmodule : cpu_arith_status_core_chk
bind cpu_arith_status_core cpu_arith_status_core_chk #(
  .DPTR_COUNT(DPTR_COUNT), .ADDR_W(ADDR_W)) chk_i (
  .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .iptr_out(iptr_out), .bank_base_out(bank_base_out));
`default_nettype wire

/* File: sim/cpu_arith_status_core_bench.sv */
// register-level bench for the cpu arithmetic and status core
`timescale 1ns/1ps
`default_nettype none
module cpu_arith_status_core_bench;
  import cpu_core_pkg::*;
  // ==============================================================
  // stimulus and observed signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic event_branch = 1'b0;
  logic [15:0] event_target = 16'h0000;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd_v;
  logic [15:0] iptr_out;
  logic [4:0] bank_base_out;
  int err_total = 0;
  int cmp_count = 0;
  always #5 aclk = ~aclk;
  cpu_arith_status_core #(.DPTR_COUNT(8), .ADDR_W(8)) dut (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .event_branch(event_branch),
    .event_target(event_target), .iptr_out(iptr_out),
    .bank_base_out(bank_base_out));
  // ==============================================================
  // compare and bus tasks
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_rsp(input string nm, input logic [1:0] e,
                         input logic [1:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_rsp
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    int n;
    aw = 1'b1;
    w = 1'b1;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while ((aw || w) && n < 100) begin
      @(posedge aclk);
      n++;
      if (awready) aw = 1'b0;
      if (wready) w = 1'b0;
      awvalid <= aw;
      wvalid <= w;
    end
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid && ++n < 100);
    rsp = bresp;
    bready <= 1'b0;
    chk("write timeout", 32'h0, {31'h0, n >= 100});
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready && ++n < 100);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid && ++n < 100);
    rd_v = rdata;
    rsp = rresp;
    rready <= 1'b0;
    chk("read timeout", 32'h0, {31'h0, n >= 100});
  endtask : rd
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    rd(a);
    chk(nm, e, rd_v);
  endtask : rchk
  task automatic cmd(input alu_op_e op, input logic [2:0] b,
                     input logic inv, input logic [15:0] t);
    wr(OFF_CMD, {t, 4'h0, inv, b, 2'b00, op});
    repeat (3) @(posedge aclk);
  endtask : cmd
  task automatic alu(input alu_op_e op, input logic [7:0] a,
                     input logic [7:0] b, input logic [7:0] e);
    wr(OFF_ACC, {24'h0, a});
    wr(OFF_OPND, {24'h0, b});
    cmd(op, 3'd0, 1'b0, 16'h0000);
    rchk("acc", OFF_ACC, {24'h0, e});
  endtask : alu
  task automatic cy(input logic e);
    rd(OFF_STATUS);
    chk("carry", {31'h0, e}, {31'h0, rd_v[STS_CARRY]});
  endtask : cy
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    #100us;
    err_total++;
    complete_run();
  end
  // ==============================================================
  // test sequence
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk("status", OFF_STATUS, 32'h00);
    rchk("stack", OFF_STACK, 32'h07);
    rchk("iptr", OFF_IPTR, 32'h0);
    wr(OFF_STACK, 32'h5a);
    chk_rsp("bresp", RESP_OKAY, rsp);
    rchk("stack", OFF_STACK, 32'h5a);
    chk_rsp("rresp", RESP_OKAY, rsp);
    wr(8'h00, 32'h1);
    chk_rsp("bresp", RESP_SLVERR, rsp);
    rd(8'h00);
    chk_rsp("rresp", RESP_SLVERR, rsp);
    alu(OP_ADD, 8'h3c, 8'hd9, 8'h15);
    rchk("status", OFF_STATUS, 32'hc1);
    alu(OP_AND, 8'h3c, 8'hd9, 8'h18);
    alu(OP_OR, 8'h3c, 8'hd9, 8'hfd);
    alu(OP_XOR, 8'h3c, 8'hd9, 8'he5);
    alu(OP_CPL, 8'h3c, 8'h00, 8'hc3);
    alu(OP_RR, 8'h3c, 8'h00, 8'h1e);
    alu(OP_RL, 8'h3c, 8'h00, 8'h78);
    alu(OP_SWAP, 8'h12, 8'h00, 8'h21);
    alu(OP_INC, 8'hff, 8'h00, 8'h00);
    alu(OP_DEC, 8'h00, 8'h00, 8'hff);
    alu(OP_ADD, 8'h70, 8'h70, 8'he0);
    rchk("status", OFF_STATUS, 32'h05);
    alu(OP_ADD, 8'h38, 8'h19, 8'h51);
    cmd(OP_DA, 3'd0, 1'b0, 16'h0000);
    rchk("acc", OFF_ACC, 32'h57);
    alu(OP_CMP, 8'h10, 8'h20, 8'h10);
    cy(1'b1);
    alu(OP_SUBB, 8'h50, 8'h20, 8'h2f);
    cmd(OP_SETC, 3'd0, 1'b0, 16'h0000);
    alu(OP_ADDC, 8'h01, 8'h01, 8'h03);
    wr(OFF_ACC, 32'h12);
    wr(OFF_BREG, 32'h34);
    cmd(OP_MUL, 3'd0, 1'b0, 16'h0000);
    rchk("acc", OFF_ACC, 32'ha8);
    rchk("breg", OFF_BREG, 32'h03);
    wr(OFF_ACC, 32'hfb);
    wr(OFF_BREG, 32'h12);
    cmd(OP_DIV, 3'd0, 1'b0, 16'h0000);
    rchk("acc", OFF_ACC, 32'h0d);
    rchk("breg", OFF_BREG, 32'h11);
    wr(OFF_ACC, 32'h00);
    wr(OFF_STATUS, 32'h01);
    rchk("status", OFF_STATUS, 32'h00);
    wr(OFF_ACC, 32'h07);
    rchk("status", OFF_STATUS, 32'h01);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_STATUS, 32'(i) << 3);
      repeat (2) @(posedge aclk);
      chk("bank base", 32'(i * 8), {27'h0, bank_base_out});
      rchk("status", OFF_STATUS, (32'(i) << 3) | 32'h1);
    end
    wr(OFF_STATUS, 32'h00);
    wr(OFF_BANK, 32'h00);
    cmd(OP_BSET, 3'd3, 1'b0, 16'h0000);
    rchk("bits", OFF_BANK, 32'h08);
    cmd(OP_BCPL, 3'd0, 1'b0, 16'h0000);
    rchk("bits", OFF_BANK, 32'h09);
    cmd(OP_BCLR, 3'd3, 1'b0, 16'h0000);
    rchk("bits", OFF_BANK, 32'h01);
    cmd(OP_JBC, 3'd0, 1'b0, 16'h1234);
    chk("iptr", 32'h1234, {16'h0, iptr_out});
    rchk("bits", OFF_BANK, 32'h00);
    cmd(OP_JNB, 3'd1, 1'b0, 16'h2222);
    chk("iptr", 32'h2222, {16'h0, iptr_out});
    cmd(OP_JB, 3'd1, 1'b0, 16'h3333);
    chk("no branch", 32'h0, {31'h0, iptr_out == 16'h3333});
    cmd(OP_SETC, 3'd0, 1'b0, 16'h0000);
    cmd(OP_ANLC, 3'd1, 1'b1, 16'h0000);
    cy(1'b1);
    cmd(OP_ANLC, 3'd1, 1'b0, 16'h0000);
    cy(1'b0);
    cmd(OP_ORLC, 3'd2, 1'b1, 16'h0000);
    cy(1'b1);
    cmd(OP_ORLC, 3'd2, 1'b0, 16'h0000);
    cy(1'b1);
    wr(OFF_STACK, 32'h07);
    cmd(OP_PUSH, 3'd0, 1'b0, 16'h0000);
    rchk("result", OFF_RESULT, 32'h08);
    cmd(OP_CALL, 3'd0, 1'b0, 16'h0000);
    rchk("stack", OFF_STACK, 32'h09);
    cmd(OP_RET, 3'd0, 1'b0, 16'h0000);
    rchk("result", OFF_RESULT, 32'h09);
    cmd(OP_POP, 3'd0, 1'b0, 16'h0000);
    rchk("result", OFF_RESULT, 32'h08);
    rchk("stack", OFF_STACK, 32'h07);
    for (int i = 0; i < 8; i++) begin
      wr(OFF_DPSEL, 32'(i));
      wr(OFF_DPTR, 32'ha500 + 32'(i * 17));
    end
    for (int i = 0; i < 8; i++) begin
      wr(OFF_DPSEL, 32'(i));
      rchk("dptr", OFF_DPTR, 32'ha500 + 32'(i * 17));
    end
    cmd(OP_JMP, 3'd0, 1'b0, 16'h0abc);
    chk("iptr", 32'h0abc, {16'h0, iptr_out});
    rchk("iptr", OFF_IPTR, 32'h0abc);
    event_target <= 16'hbeef;
    event_branch <= 1'b1;
    cmd(OP_NOP, 3'd0, 1'b0, 16'h0000);
    event_branch <= 1'b0;
    clk_en <= 1'b0;
    repeat (4) @(posedge aclk);
    clk_en <= 1'b1;
    @(posedge aclk);
    chk("iptr", 32'hbeef, {16'h0, iptr_out});
    complete_run();
  end
endmodule : cpu_arith_status_core_bench
`default_nettype wire
